// >>> hw/etp_pkg.sv
// Package: register map, field layout and constants of the 8-bit timer/PWM unit
package etp_pkg;
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_COUNT = 2'h1;
    localparam logic [1:0] ADDR_COMPARE = 2'h2;
    localparam logic [1:0] ADDR_FLAGS = 2'h3;
    localparam int BIT_FORCE = 7;
    localparam int BIT_WGM_HI = 6;
    localparam int BIT_COM_HI = 5;
    localparam int BIT_COM_LO = 4;
    localparam int BIT_WGM_LO = 3;
    localparam int BIT_CS_HI = 2;
    localparam int BIT_FLAG_CMP = 1;
    localparam int BIT_FLAG_OVF = 0;
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE = 2'h1;
    localparam logic [1:0] WGM_CTC = 2'h2;
    localparam logic [1:0] WGM_FAST = 2'h3;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRE_MASK8 = 10'h007;
    localparam logic [9:0] PRE_MASK64 = 10'h03f;
    localparam logic [9:0] PRE_MASK256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK1024 = 10'h3ff;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// >>> hw/etp_timer.sv
// 8-bit timer/counter with one compare channel and PWM waveform unit
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
// Notes on behaviour
// - Logic runs on ref_clk; the selected tick is only a clock enable.
// - Force strobe acts only when low waveform bit selects a non-PWM mode.
// - Force strobe write causes an immediate match action on the output.
// - Forced match sets no flag and does not clear the counter.
// - Force bit always reads as zero.
// - Waveform field at bits 6,3: normal, phase PWM, CTC, fast PWM.
// - TOP is 0xff, except compare value in CTC mode.
// - Compare buffered till TOP in PWM; overflow at MAX, phase mode at BOTTOM.
// - Nonzero output mode overrides port; pin drives only with direction set.
// - Non-PWM codes: off, toggle, clear, set on match.
// - Fast PWM: 2 clear on match set at TOP, 3 inverse, 1 reserved.
// - Phase PWM: 2 clear up-match set down-match, 3 inverse, 1 reserved.
// - PWM with compare equal TOP and high mode bit: match ignored, TOP action.
// - Clock select: stop, /1, /8, /64, /256, /1024.
// - Codes 6 and 7 count falling or rising edges of the count pin.
// - External pin clocks the counter even when configured as output.
// - Count register gives direct read and write of the counter.
// - Count write blocks any compare match on the next tick.
// - Compare continuously; match sets compare flag and drives waveform.
// - Fast PWM counts up to MAX then clears to BOTTOM next tick.
// - Phase PWM reverses at MAX and holds MAX for exactly one tick.
// - Compare flag clears on vector acknowledge or software writing one.
module etp_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt acknowledge from the vector logic
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    // Pins
    input wire logic external_count_pin,
    input wire logic port_direction_out,
    input wire logic port_data,
    output logic compare_output_pin,
    output logic compare_output_pin_oe_n,
    // Flags
    output logic compare_match_flag,
    output logic overflow_flag
);
    typedef struct packed {
        logic [1:0] wgm;
        logic [1:0] com;
        logic [2:0] cs;
        logic [7:0] cnt;
        logic [7:0] ocr;
        logic [7:0] ocr_buf;
        logic dir_down;
        logic wave;
        logic block;
        logic ext_prev;
        logic [9:0] pre;
        logic ocf;
        logic tov;
        logic [7:0] rdata;
    } etp_state_t;

    etp_state_t s_q;
    etp_state_t s_d;
    logic tick;
    logic pwm;
    logic [7:0] top;
    logic match;
    logic wr_ctl;
    logic wr_cnt;
    logic wr_ocr;
    logic wr_flg;
    logic force_cmp;
    logic at_top;
    logic ovf_set;
    logic [1:0] wgm_new;

    assign pwm = s_q.wgm[0];
    assign wr_ctl = reg_wr && reg_addr == etp_pkg::ADDR_CONTROL;
    assign wr_cnt = reg_wr && reg_addr == etp_pkg::ADDR_COUNT;
    assign wr_ocr = reg_wr && reg_addr == etp_pkg::ADDR_COMPARE;
    assign wr_flg = reg_wr && reg_addr == etp_pkg::ADDR_FLAGS;
    assign wgm_new = {reg_wdata[etp_pkg::BIT_WGM_HI], reg_wdata[etp_pkg::BIT_WGM_LO]};
    // Force judged against the mode being written, ignored in PWM
    assign force_cmp = wr_ctl && reg_wdata[etp_pkg::BIT_FORCE] && !wgm_new[0];
    assign top = (s_q.wgm == etp_pkg::WGM_CTC) ? s_q.ocr_buf : etp_pkg::CNT_MAX;
    assign match = tick && !s_q.block && s_q.cnt == s_q.ocr_buf;
    // Overflow event, so that a clear in the same cycle loses to it
    assign ovf_set = tick && ((s_q.wgm == etp_pkg::WGM_PHASE)
        ? (s_q.dir_down && s_q.cnt == etp_pkg::CNT_BOTTOM)
        : (s_q.cnt == etp_pkg::CNT_MAX));

    // Prescaler tick select; pin edge seen regardless of pin direction
    always_comb begin
        unique case (s_q.cs)
            etp_pkg::CS_STOP: tick = 1'b0;
            etp_pkg::CS_DIV1: tick = 1'b1;
            etp_pkg::CS_DIV8: tick = (s_q.pre & etp_pkg::PRE_MASK8) == etp_pkg::PRE_MASK8;
            etp_pkg::CS_DIV64: tick = (s_q.pre & etp_pkg::PRE_MASK64) == etp_pkg::PRE_MASK64;
            etp_pkg::CS_DIV256: tick = (s_q.pre & etp_pkg::PRE_MASK256) == etp_pkg::PRE_MASK256;
            etp_pkg::CS_DIV1024: tick = s_q.pre == etp_pkg::PRE_MASK1024;
            etp_pkg::CS_EXT_FALL: tick = s_q.ext_prev && !external_count_pin;
            etp_pkg::CS_EXT_RISE: tick = !s_q.ext_prev && external_count_pin;
        endcase
    end

    always_comb begin
        s_d = s_q;
        at_top = 1'b0;
        s_d.pre = s_q.pre + 10'h001;
        s_d.ext_prev = external_count_pin;
        s_d.block = s_q.block && !tick;
        // Counter sequencing
        if (tick) begin
            unique case (s_q.wgm)
                etp_pkg::WGM_PHASE: begin
                    if (!s_q.dir_down) begin
                        if (s_q.cnt == etp_pkg::CNT_MAX) begin
                            s_d.dir_down = 1'b1;
                            s_d.cnt = s_q.cnt - 8'h01;
                        end else begin
                            s_d.cnt = s_q.cnt + 8'h01;
                        end
                    end else if (s_q.cnt == etp_pkg::CNT_BOTTOM) begin
                        s_d.dir_down = 1'b0;
                        s_d.cnt = s_q.cnt + 8'h01;
                        s_d.tov = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt - 8'h01;
                    end
                    at_top = s_q.cnt == etp_pkg::CNT_MAX;
                end
                etp_pkg::WGM_CTC: begin
                    if (s_q.cnt == top) begin
                        s_d.cnt = etp_pkg::CNT_BOTTOM;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                    if (s_q.cnt == etp_pkg::CNT_MAX) begin
                        s_d.tov = 1'b1;
                    end
                end
                default: begin
                    s_d.cnt = s_q.cnt + 8'h01;
                    at_top = s_q.cnt == etp_pkg::CNT_MAX;
                    if (s_q.cnt == etp_pkg::CNT_MAX) begin
                        s_d.tov = 1'b1;
                    end
                end
            endcase
            s_d.dir_down = (s_q.wgm == etp_pkg::WGM_PHASE) ? s_d.dir_down : 1'b0;
        end
        // Compare buffer loads at TOP in PWM, else follows directly
        if (!pwm || (tick && at_top)) begin
            s_d.ocr_buf = s_q.ocr;
        end
        // Waveform unit
        if (match) begin
            s_d.ocf = 1'b1;
        end
        if (force_cmp) begin
            unique case (s_q.com)
                etp_pkg::COM_TOGGLE: s_d.wave = !s_q.wave;
                etp_pkg::COM_CLEAR: s_d.wave = 1'b0;
                etp_pkg::COM_SET: s_d.wave = 1'b1;
                default: s_d.wave = s_q.wave;
            endcase
        end else if (!pwm && match) begin
            unique case (s_q.com)
                etp_pkg::COM_TOGGLE: s_d.wave = !s_q.wave;
                etp_pkg::COM_CLEAR: s_d.wave = 1'b0;
                etp_pkg::COM_SET: s_d.wave = 1'b1;
                default: s_d.wave = s_q.wave;
            endcase
        end else if (pwm && s_q.com[1]) begin
            if (s_q.wgm == etp_pkg::WGM_FAST) begin
                if (tick && at_top) begin
                    s_d.wave = !s_q.com[0];
                end else if (match && s_q.ocr_buf != etp_pkg::CNT_MAX) begin
                    s_d.wave = s_q.com[0];
                end
            end else begin
                // At TOP with compare at MAX the pin takes the down-match level
                if (tick && at_top && s_q.ocr_buf == etp_pkg::CNT_MAX) begin
                    s_d.wave = !s_q.com[0];
                end else if (match && s_q.ocr_buf != etp_pkg::CNT_MAX) begin
                    s_d.wave = s_q.dir_down ? !s_q.com[0] : s_q.com[0];
                end
            end
        end
        // Flag clears; a set in the same cycle wins
        if ((compare_vector_ack || (wr_flg && reg_wdata[etp_pkg::BIT_FLAG_CMP])) && !match) begin
            s_d.ocf = 1'b0;
        end
        if ((overflow_vector_ack || (wr_flg && reg_wdata[etp_pkg::BIT_FLAG_OVF]))
                && !ovf_set) begin
            s_d.tov = 1'b0;
        end
        // Register writes
        if (wr_ctl) begin
            s_d.wgm = wgm_new;
            s_d.com = reg_wdata[etp_pkg::BIT_COM_HI:etp_pkg::BIT_COM_LO];
            s_d.cs = reg_wdata[etp_pkg::BIT_CS_HI:0];
        end
        if (wr_cnt) begin
            s_d.cnt = reg_wdata;
            s_d.block = 1'b1;
        end
        if (wr_ocr) begin
            s_d.ocr = reg_wdata;
        end
        // Read data, one cycle after strobe
        s_d.rdata = etp_pkg::RESET_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                etp_pkg::ADDR_CONTROL: s_d.rdata = {1'b0, s_q.wgm[1], s_q.com, s_q.wgm[0],
                    s_q.cs};
                etp_pkg::ADDR_COUNT: s_d.rdata = s_q.cnt;
                etp_pkg::ADDR_COMPARE: s_d.rdata = s_q.ocr;
                etp_pkg::ADDR_FLAGS: s_d.rdata = {6'h00, s_q.ocf, s_q.tov};
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign compare_match_flag = s_q.ocf;
    assign overflow_flag = s_q.tov;
    // Pin override when mode nonzero; pin enable follows direction alone
    always_comb begin
        compare_output_pin = (s_q.com != etp_pkg::COM_OFF) ? s_q.wave : port_data;
        compare_output_pin_oe_n = !port_direction_out;
    end

    a_force_no_flag: assert property (@(posedge ref_clk) disable iff (rst)
        (force_cmp && !match && !s_q.ocf) |=> !s_q.ocf) else $error("force set flag");
    a_force_pwm_ignored: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctl && wgm_new[0] && pwm && !tick) |=> $stable(s_q.wave))
        else $error("force acted in pwm");
    a_force_read_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == etp_pkg::ADDR_CONTROL) |=> !reg_rdata[etp_pkg::BIT_FORCE])
        else $error("force bit read one");
    a_ctc_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_q.wgm == etp_pkg::WGM_CTC && s_q.cnt == top && !reg_wr)
        |=> s_q.cnt == etp_pkg::CNT_BOTTOM) else $error("ctc no clear");
    a_count_write_block: assert property (@(posedge ref_clk) disable iff (rst)
        wr_cnt |=> (s_q.block && !match)) else $error("match after count write");
    a_match_flag: assert property (@(posedge ref_clk) disable iff (rst)
        match |=> s_q.ocf) else $error("match lost flag");
    a_phase_hold_max: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_q.wgm == etp_pkg::WGM_PHASE && s_q.cnt == 8'hfe && !s_q.dir_down && !reg_wr)
        |=> s_q.cnt == etp_pkg::CNT_MAX && !s_q.dir_down) else $error("phase max");
    a_fast_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_q.wgm == etp_pkg::WGM_FAST && s_q.cnt == etp_pkg::CNT_MAX && !reg_wr)
        |=> s_q.cnt == etp_pkg::CNT_BOTTOM && s_q.tov) else $error("fast wrap");
    a_stop_holds: assert property (@(posedge ref_clk) disable iff (rst)
        (s_q.cs == etp_pkg::CS_STOP && !reg_wr) |=> $stable(s_q.cnt))
        else $error("stopped counter moved");
    // Counter and flag checks
    a_block_no_match: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.block
        |-> !match)
        else $error("match while blocked");
    a_match_needs_tick: assert property (@(posedge ref_clk) disable iff (rst)
        match
        |-> tick)
        else $error("match without tick");
    a_ovf_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
        ovf_set
        |=> s_q.tov)
        else $error("overflow lost");
    a_phase_ovf_bottom: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_q.wgm == etp_pkg::WGM_PHASE && s_q.dir_down && s_q.cnt == etp_pkg::CNT_BOTTOM)
        |=> s_q.tov)
        else $error("phase overflow missed");
    a_ctc_flag: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_q.wgm == etp_pkg::WGM_CTC && s_q.cnt == top && !s_q.block)
        |=> s_q.ocf)
        else $error("ctc flag missed");
    // Compare buffer checks
    a_buf_direct: assert property (@(posedge ref_clk) disable iff (rst)
        !pwm
        |=> s_q.ocr_buf == $past(s_q.ocr))
        else $error("compare buffer not direct");
    a_buf_held_pwm: assert property (@(posedge ref_clk) disable iff (rst)
        (pwm && !(tick && at_top))
        |=> $stable(s_q.ocr_buf))
        else $error("compare buffer moved in pwm");
    // Pin and read port checks
    a_oe_follows_dir: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1
        |-> compare_output_pin_oe_n == !port_direction_out)
        else $error("pin enable wrong");
    a_pin_port_off: assert property (@(posedge ref_clk) disable iff (rst)
        (s_q.com == etp_pkg::COM_OFF)
        |-> compare_output_pin == port_data)
        else $error("pin not port when off");
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst)
        !reg_rd
        |=> reg_rdata == etp_pkg::RESET_BYTE)
        else $error("read data without read");
    // Waveform checks
    a_nonpwm_toggle: assert property (@(posedge ref_clk) disable iff (rst)
        (match && !pwm && s_q.com == etp_pkg::COM_TOGGLE && !reg_wr)
        |=> s_q.wave != $past(s_q.wave))
        else $error("toggle missed");
    a_fast_top_set: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_q.wgm == etp_pkg::WGM_FAST && s_q.com[1] && at_top && !reg_wr)
        |=> s_q.wave == !$past(s_q.com[0]))
        else $error("fast top action missed");
    a_phase_top_max: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_q.wgm == etp_pkg::WGM_PHASE && s_q.com[1] && at_top
            && s_q.ocr_buf == etp_pkg::CNT_MAX && !reg_wr)
        |=> s_q.wave == !$past(s_q.com[0]))
        else $error("phase top action missed");
    a_phase_down_match: assert property (@(posedge ref_clk) disable iff (rst)
        (match && s_q.wgm == etp_pkg::WGM_PHASE && s_q.com[1] && s_q.dir_down
            && s_q.ocr_buf != etp_pkg::CNT_MAX && !reg_wr)
        |=> s_q.wave == !$past(s_q.com[0]))
        else $error("phase down match missed");
endmodule // etp_timer

// >>> verif/etp_timer_bench.sv
// Self-checking testbench for the 8-bit timer/PWM unit
`timescale 1ns/1ns
module etp_timer_bench;
    logic ref_clk, rst, reg_wr, reg_rd, compare_vector_ack, overflow_vector_ack;
    logic external_count_pin, port_direction_out, port_data;
    logic compare_output_pin, compare_output_pin_oe_n, compare_match_flag, overflow_flag;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    int err_count, checked;

    etp_timer dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .compare_vector_ack(compare_vector_ack), .overflow_vector_ack(overflow_vector_ack),
        .external_count_pin(external_count_pin), .port_direction_out(port_direction_out),
        .port_data(port_data), .compare_output_pin(compare_output_pin),
        .compare_output_pin_oe_n(compare_output_pin_oe_n),
        .compare_match_flag(compare_match_flag), .overflow_flag(overflow_flag));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] ctl(logic [1:0] m, logic [1:0] c, logic [2:0] s, logic f);
        return {f, m[1], c, m[0], s};
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(logic [7:0] g, logic [7:0] e);
        checked++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            err_count++;
        end
    endtask

    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [1:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    // Bounded wait on the compare flag (sel 1) or the overflow flag (sel 0)
    task automatic wait_flag(logic sel, int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge ref_clk);
            if ((sel ? compare_match_flag : overflow_flag) === 1'b1) return;
        end
        chk(8'h00, 8'h01);
        print_verdict();
    endtask

    task automatic pulse_ext();
        repeat (5) begin
            @(posedge ref_clk);
            external_count_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            external_count_pin <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
        rd(etp_pkg::ADDR_COUNT);
    endtask

    task automatic t_reset();
        for (int a = 0; a < 4; a++) begin
            rd(2'(a));
            chk(rv, etp_pkg::RESET_BYTE);
        end
        chk({7'h0, compare_output_pin_oe_n}, 8'h01);
        @(posedge ref_clk);
        port_data <= 1'b1;
        port_direction_out <= 1'b1;
        @(negedge ref_clk);
        chk({7'h0, compare_output_pin, compare_output_pin_oe_n}, 8'h02);
    endtask

    task automatic t_force();
        logic [1:0] fm [4] = '{etp_pkg::WGM_NORMAL, etp_pkg::WGM_NORMAL, etp_pkg::WGM_CTC,
            etp_pkg::WGM_CTC};
        logic [1:0] fc [4] = '{etp_pkg::COM_TOGGLE, etp_pkg::COM_CLEAR, etp_pkg::COM_SET,
            etp_pkg::COM_TOGGLE};
        logic [3:0] fe = 4'b0101;
        wr(etp_pkg::ADDR_COUNT, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(etp_pkg::ADDR_CONTROL, ctl(fm[i], fc[i], etp_pkg::CS_STOP, 1'b0));
            wr(etp_pkg::ADDR_CONTROL, ctl(fm[i], fc[i], etp_pkg::CS_STOP, 1'b1));
            repeat (2) @(negedge ref_clk);
            chk({7'h0, compare_output_pin}, {7'h0, fe[i]});
        end
        wr(etp_pkg::ADDR_CONTROL, ctl(etp_pkg::WGM_FAST, etp_pkg::COM_SET, etp_pkg::CS_STOP, 1'b1));
        repeat (2) @(negedge ref_clk);
        chk({7'h0, compare_output_pin}, 8'h00);
        rd(etp_pkg::ADDR_CONTROL);
        chk(rv, ctl(etp_pkg::WGM_FAST, etp_pkg::COM_SET, etp_pkg::CS_STOP, 1'b0));
        rd(etp_pkg::ADDR_COUNT);
        chk(rv, 8'h40);
        chk({6'h0, compare_match_flag, overflow_flag}, 8'h00);
    endtask

    task automatic t_ctc();
        wr(etp_pkg::ADDR_COMPARE, 8'h03);
        rd(etp_pkg::ADDR_COMPARE);
        chk(rv, 8'h03);
        wr(etp_pkg::ADDR_COUNT, 8'h00);
        wr(etp_pkg::ADDR_CONTROL, ctl(etp_pkg::WGM_CTC, etp_pkg::COM_TOGGLE, etp_pkg::CS_DIV1, 1'b0));
        for (int i = 0; i < 20; i++) begin
            rd(etp_pkg::ADDR_COUNT);
            chk({7'h0, rv > 8'h03}, 8'h00);
        end
        wait_flag(1'b1, 20);
        wr(etp_pkg::ADDR_CONTROL, ctl(etp_pkg::WGM_CTC, etp_pkg::COM_OFF, etp_pkg::CS_STOP, 1'b0));
        compare_vector_ack <= 1'b1;
        @(posedge ref_clk);
        compare_vector_ack <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({6'h0, compare_match_flag, overflow_flag}, 8'h00);
    endtask

    task automatic t_overflow(logic [1:0] m, int quiet);
        wr(etp_pkg::ADDR_COUNT, m == etp_pkg::WGM_PHASE ? 8'h02 : 8'hfc);
        wr(etp_pkg::ADDR_CONTROL, ctl(m, etp_pkg::COM_OFF, etp_pkg::CS_DIV1, 1'b0));
        repeat (quiet + 1) @(negedge ref_clk);
        chk({7'h0, overflow_flag}, 8'h00);
        wait_flag(1'b0, 300);
        wr(etp_pkg::ADDR_CONTROL, 8'h00);
        overflow_vector_ack <= 1'b1;
        @(posedge ref_clk);
        overflow_vector_ack <= 1'b0;
        @(negedge ref_clk);
        chk({7'h0, overflow_flag}, 8'h00);
    endtask

    task automatic t_suppress();
        wr(etp_pkg::ADDR_COMPARE, 8'h20);
        wr(etp_pkg::ADDR_FLAGS, 8'h03);
        wr(etp_pkg::ADDR_CONTROL, ctl(etp_pkg::WGM_NORMAL, etp_pkg::COM_OFF, etp_pkg::CS_DIV1, 1'b0));
        wr(etp_pkg::ADDR_COUNT, 8'h20);
        repeat (4) @(negedge ref_clk);
        chk({7'h0, compare_match_flag}, 8'h00);
        wr(etp_pkg::ADDR_COUNT, 8'h1c);
        wait_flag(1'b1, 12);
        wr(etp_pkg::ADDR_CONTROL, 8'h00);
        wr(etp_pkg::ADDR_FLAGS, 8'h02);
        @(negedge ref_clk);
        chk({7'h0, compare_match_flag}, 8'h00);
    endtask

    task automatic t_prescale();
        logic [7:0] ex [5] = '{8'hd0, 8'hfa, 8'h1f, 8'h07, 8'h01};
        logic [7:0] d;
        for (int s = 1; s < 6; s++) begin
            wr(etp_pkg::ADDR_CONTROL, 8'h00);
            wr(etp_pkg::ADDR_COUNT, 8'h00);
            wr(etp_pkg::ADDR_CONTROL, ctl(etp_pkg::WGM_NORMAL, etp_pkg::COM_OFF, 3'(s), 1'b0));
            repeat (2000) @(posedge ref_clk);
            wr(etp_pkg::ADDR_CONTROL, 8'h00);
            rd(etp_pkg::ADDR_COUNT);
            d = rv - ex[s - 1];
            chk({7'h0, d > 8'h03 && d < 8'hfd}, 8'h00);
        end
    endtask

    task automatic t_external();
        wr(etp_pkg::ADDR_COUNT, 8'h00);
        wr(etp_pkg::ADDR_CONTROL, {5'h0, etp_pkg::CS_EXT_RISE});
        pulse_ext();
        chk(rv, 8'h05);
        wr(etp_pkg::ADDR_COUNT, 8'h00);
        wr(etp_pkg::ADDR_CONTROL, {5'h0, etp_pkg::CS_EXT_FALL});
        pulse_ext();
        chk(rv, 8'h05);
    endtask

    // High time of the non-inverted PWM output, in clocks
    task automatic t_pwm(logic [1:0] m, logic [7:0] c, int lo, int hi);
        int n;
        wr(etp_pkg::ADDR_CONTROL, 8'h00);
        wr(etp_pkg::ADDR_COMPARE, c);
        wr(etp_pkg::ADDR_CONTROL, ctl(m, etp_pkg::COM_CLEAR, etp_pkg::CS_DIV1, 1'b0));
        for (n = 0; n < 600 && compare_output_pin !== 1'b0; n++) @(negedge ref_clk);
        for (n = 0; n < 600 && compare_output_pin !== 1'b1; n++) @(negedge ref_clk);
        for (n = 0; n < 600 && compare_output_pin === 1'b1; n++) @(negedge ref_clk);
        chk({7'h0, n < lo || n > hi}, 8'h00);
        if (n >= 600) print_verdict();
    endtask

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        compare_vector_ack = 1'b0;
        overflow_vector_ack = 1'b0;
        external_count_pin = 1'b0;
        port_direction_out = 1'b0;
        port_data = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_force();
        t_ctc();
        t_overflow(etp_pkg::WGM_NORMAL, 0);
        t_overflow(etp_pkg::WGM_PHASE, 300);
        t_suppress();
        t_prescale();
        t_external();
        t_pwm(etp_pkg::WGM_FAST, 8'h10, 15, 17);
        t_pwm(etp_pkg::WGM_PHASE, 8'h80, 254, 258);
        print_verdict();
    end
endmodule // etp_timer_bench
